/* shared/adc_front_pkg.sv */
// package: register map, field layouts, reset values and mux codes for the converter front end
// Functional notes
// - codes 0-15 port 0/1, 16-22 port 2
// - four reserved codes, sensor, then battery at 11100
// - 11101 regulator, 11110 supply, 11111 ground
// - select register bits 7:5 read zero
// - sensor code routes sensor to positive input
// - sensor disabled means output high impedance
// - offset high shows offset bits 9:2
// - offset low shows bits 1:0 at 7:6
// - offset value is device specific, not reset
// - reference mux picks one of four sources
// - ground mux picks ground pin or analog pin
// - reference select codes 00,01,10,11
// - ground select 0 pin, 1 analog pin
// - high-speed reference on only while converter needs
// - sensor enable at reference control bit 2
package adc_front_pkg;
    // register addresses on the special-function-register bus
    localparam logic [7:0] OFFSET_LOW_ADDR = 8'h85;
    localparam logic [7:0] OFFSET_HIGH_ADDR = 8'h86;
    localparam logic [7:0] INPUT_SELECT_ADDR = 8'hBB;
    localparam logic [7:0] REFERENCE_CONTROL_ADDR = 8'hD1;
    // reset values
    localparam logic [4:0] INPUT_SELECT_RESET = 5'h1F;
    localparam logic [1:0] REF_SOURCE_RESET = 2'h3;
    localparam logic GROUND_SELECT_RESET = 1'b0;
    localparam logic SENSOR_ENABLE_RESET = 1'b0;
    localparam logic PRECISION_ENABLE_RESET = 1'b0;
    // reference control field positions
    localparam int REF_PRECISION_BIT = 0;
    localparam int REF_SENSOR_BIT = 2;
    localparam int REF_SOURCE_LSB = 3;
    localparam int REF_GROUND_BIT = 5;
    // offset low field position
    localparam int OFFSET_LOW_LSB = 6;
    // positive input codes
    localparam logic [4:0] CODE_PORT01_LAST = 5'h0F;
    localparam logic [4:0] CODE_PORT2_FIRST = 5'h10;
    localparam logic [4:0] CODE_PORT2_LAST = 5'h16;
    localparam logic [4:0] CODE_SENSOR = 5'h1B;
    localparam logic [4:0] CODE_BATTERY = 5'h1C;
    localparam logic [4:0] CODE_REGULATOR = 5'h1D;
    localparam logic [4:0] CODE_SUPPLY = 5'h1E;
    localparam logic [4:0] CODE_GROUND = 5'h1F;
    // reference source selection
    typedef enum logic [1:0] {
        REF_EXT_PIN = 2'b00,
        REF_MAIN_SUPPLY = 2'b01,
        REF_DIGITAL_SUPPLY = 2'b10,
        REF_HIGH_SPEED = 2'b11
    } ref_source_t;
    // one-hot routing of the positive input
    typedef struct packed {
        logic [15:0] port01;
        logic [6:0] port2;
        logic sensor;
        logic battery;
        logic regulator;
        logic supply;
        logic ground;
    } input_route_t;
    // reference and ground routing
    typedef struct packed {
        logic ext_pin;
        logic main_supply;
        logic digital_supply;
        logic high_speed;
        logic high_speed_on;
        logic precision_on;
        logic analog_ground;
    } ref_route_t;
    // register bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;
endpackage : adc_front_pkg

/* rtl/input_decoder.sv */
// decoder from the positive input select code to one-hot routing
`timescale 1ns/1ps
module input_decoder (
    // select code
    input wire logic [4:0] code,
    // routing
    output adc_front_pkg::input_route_t route
);
    // one-hot decode of the select code
    always_comb begin
        route = '0;
        if (code <= adc_front_pkg::CODE_PORT01_LAST) begin
            route.port01[code[3:0]] = 1'b1;
        end else if (code <= adc_front_pkg::CODE_PORT2_LAST) begin
            route.port2[3'(code - adc_front_pkg::CODE_PORT2_FIRST)] = 1'b1;
        end else begin
            unique case (code)
                adc_front_pkg::CODE_SENSOR: route.sensor = 1'b1;
                adc_front_pkg::CODE_BATTERY: route.battery = 1'b1;
                adc_front_pkg::CODE_REGULATOR: route.regulator = 1'b1;
                adc_front_pkg::CODE_SUPPLY: route.supply = 1'b1;
                adc_front_pkg::CODE_GROUND: route.ground = 1'b1;
                default: route = '0;
            endcase
        end
    end
endmodule : input_decoder

/* rtl/adc_front_ctrl.sv */
// register file and routing control for the converter front end
`timescale 1ns/1ps
module adc_front_ctrl (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    // register bus
    input wire adc_front_pkg::sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // production offset value, fixed by trim
    input wire logic [9:0] temp_sensor_offset_value,
    // converter activity
    input wire logic converter_busy,
    // analog controls
    output adc_front_pkg::input_route_t analog_input_mux,
    output adc_front_pkg::ref_route_t ref_route,
    output logic temp_sensor_enable
);
    // all state of the block
    typedef struct packed {
        logic [4:0] positive_input_select;
        logic [1:0] reference_source_select;
        logic ground_reference_select;
        logic sensor_en;
        logic precision_en;
        logic [7:0] rdata;
        logic hit;
        adc_front_pkg::input_route_t route;
        adc_front_pkg::ref_route_t refs;
    } state_t;

    state_t st_q;
    state_t st_d;
    adc_front_pkg::input_route_t route_next;

    // decode of the select code to be registered
    input_decoder u_dec (
        .code(st_d.positive_input_select),
        .route(route_next)
    );

    // next-state logic
    always_comb begin
        st_d = st_q;
        st_d.hit = 1'b0;
        if (sfr_req.wr) begin
            unique case (sfr_req.addr)
                // upper bits dropped, code kept as written
                adc_front_pkg::INPUT_SELECT_ADDR: st_d.positive_input_select = sfr_req.wdata[4:0];
                adc_front_pkg::REFERENCE_CONTROL_ADDR: begin
                    st_d.sensor_en = sfr_req.wdata[adc_front_pkg::REF_SENSOR_BIT];
                    st_d.reference_source_select = sfr_req.wdata[adc_front_pkg::REF_SOURCE_LSB +: 2];
                    st_d.ground_reference_select = sfr_req.wdata[adc_front_pkg::REF_GROUND_BIT];
                    st_d.precision_en = sfr_req.wdata[adc_front_pkg::REF_PRECISION_BIT];
                end
                // offset registers ignore writes
                default: ;
            endcase
        end
        if (sfr_req.rd) begin
            st_d.hit = 1'b1;
            st_d.rdata = 8'h00;
            unique case (sfr_req.addr)
                adc_front_pkg::INPUT_SELECT_ADDR: st_d.rdata = {3'h0, st_q.positive_input_select};
                adc_front_pkg::OFFSET_HIGH_ADDR: st_d.rdata = temp_sensor_offset_value[9:2];
                adc_front_pkg::OFFSET_LOW_ADDR:
                    st_d.rdata = {temp_sensor_offset_value[1:0], 6'h00};
                adc_front_pkg::REFERENCE_CONTROL_ADDR: begin
                    st_d.rdata[adc_front_pkg::REF_GROUND_BIT] = st_q.ground_reference_select;
                    st_d.rdata[adc_front_pkg::REF_SOURCE_LSB +: 2] = st_q.reference_source_select;
                    st_d.rdata[adc_front_pkg::REF_SENSOR_BIT] = st_q.sensor_en;
                    st_d.rdata[adc_front_pkg::REF_PRECISION_BIT] = st_q.precision_en;
                end
                // unmapped address misses
                default: st_d.hit = 1'b0;
            endcase
        end
        st_d.route = route_next;
        st_d.refs = '0;
        unique case (adc_front_pkg::ref_source_t'(st_d.reference_source_select))
            adc_front_pkg::REF_EXT_PIN: st_d.refs.ext_pin = 1'b1;
            adc_front_pkg::REF_MAIN_SUPPLY: st_d.refs.main_supply = 1'b1;
            adc_front_pkg::REF_DIGITAL_SUPPLY: st_d.refs.digital_supply = 1'b1;
            adc_front_pkg::REF_HIGH_SPEED: st_d.refs.high_speed = 1'b1;
        endcase
        // high-speed reference powered only while converting
        st_d.refs.high_speed_on = st_d.refs.high_speed & converter_busy;
        st_d.refs.precision_on = st_d.precision_en;
        st_d.refs.analog_ground = st_d.ground_reference_select;
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
            st_q.positive_input_select <= adc_front_pkg::INPUT_SELECT_RESET;
            st_q.reference_source_select <= adc_front_pkg::REF_SOURCE_RESET;
            st_q.ground_reference_select <= adc_front_pkg::GROUND_SELECT_RESET;
            st_q.sensor_en <= adc_front_pkg::SENSOR_ENABLE_RESET;
            st_q.precision_en <= adc_front_pkg::PRECISION_ENABLE_RESET;
            st_q.route.ground <= 1'b1;
            st_q.refs.high_speed <= 1'b1;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state
    assign sfr_rdata = st_q.rdata;
    assign sfr_hit = st_q.hit;
    assign analog_input_mux = st_q.route;
    assign ref_route = st_q.refs;
    assign temp_sensor_enable = st_q.sensor_en;
endmodule : adc_front_ctrl

/* testbench/adc_front_checker.sv */
// checker: port relations of the front-end control block
`timescale 1ns/1ps
module adc_front_checker (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    // register bus
    input wire adc_front_pkg::sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    // analog side
    input wire logic [9:0] temp_sensor_offset_value,
    input wire logic converter_busy,
    input wire adc_front_pkg::input_route_t analog_input_mux,
    input wire adc_front_pkg::ref_route_t ref_route,
    input wire logic temp_sensor_enable
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // request taken at one address
    sequence rd_s(logic [7:0] a);
        clk_en && sfr_req.rd && sfr_req.addr == a;
    endsequence
    sequence wr_s(logic [7:0] a);
        clk_en && sfr_req.wr && sfr_req.addr == a;
    endsequence
    sel_read_a: assert property (rd_s(8'hBB) |=> sfr_hit && sfr_rdata[7:5] == 3'h0)
        else $error("select read");
    off_high_a: assert property (rd_s(8'h86) |=> sfr_rdata == temp_sensor_offset_value[9:2])
        else $error("offset high");
    off_low_a: assert property (rd_s(8'h85) |=> sfr_rdata == {temp_sensor_offset_value[1:0], 6'h00})
        else $error("offset low");
    sensor_route_a: assert property (wr_s(8'hBB) ##0 sfr_req.wdata[4:0] == 5'h1B |=> analog_input_mux.sensor)
        else $error("sensor route");
    ref_source_a: assert property (wr_s(8'hD1) |=> ref_route[6:3] == 4'h8 >> $past(sfr_req.wdata[4:3]))
        else $error("reference source");
    ground_sel_a: assert property (wr_s(8'hD1) |=> ref_route.analog_ground == $past(sfr_req.wdata[5]))
        else $error("ground select");
    sensor_en_a: assert property (wr_s(8'hD1) |=> temp_sensor_enable == $past(sfr_req.wdata[2]))
        else $error("sensor enable");
    // on exactly while selected and busy, reset edges excluded
    hs_auto_a: assert property ($past(clk_en) && !$past(sys_rst) |->
        ref_route.high_speed_on == (ref_route.high_speed && $past(converter_busy)))
        else $error("high speed on");
endmodule : adc_front_checker

/* testbench/analog_core_model.sv */
// converter core stand-in: trim value and conversion activity
`timescale 1ns/1ps
module analog_core_model #(
    // production trim, value arbitrary
    parameter logic [9:0] TRIM = 10'h2C9
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // converter side
    output logic [9:0] temp_sensor_offset_value,
    output logic converter_busy
);
    // conversion phase counter
    logic [2:0] phase_q;
    assign temp_sensor_offset_value = TRIM;
    // phase moves off the sampling edge
    always @(negedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            phase_q <= 3'h0;
        end else begin
            phase_q <= phase_q + 3'h1;
        end
    end
    assign converter_busy = (phase_q < 3'h3);
endmodule : analog_core_model

/* testbench/tb_top.sv */
// testbench: register accesses and routing of the front end
`timescale 1ns/1ps
module tb_top;
    localparam logic [9:0] TRIM = 10'h2C9;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    adc_front_pkg::sfr_req_t sfr_req = '0;
    logic [7:0] sfr_rdata;
    logic sfr_hit;
    logic [9:0] temp_sensor_offset_value;
    logic converter_busy;
    adc_front_pkg::input_route_t analog_input_mux;
    adc_front_pkg::input_route_t exp_route;
    adc_front_pkg::ref_route_t ref_route;
    logic temp_sensor_enable;
    logic busy_seen;
    int miscompares = 0;
    int checked = 0;
    always #50 clock = ~clock;
    adc_front_ctrl i_adc_front_ctrl (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .converter_busy(converter_busy),
        .temp_sensor_offset_value(temp_sensor_offset_value), .analog_input_mux(analog_input_mux),
        .ref_route(ref_route), .temp_sensor_enable(temp_sensor_enable));
    analog_core_model #(.TRIM(TRIM)) i_analog_core_model (.clock(clock), .sys_rst(sys_rst),
        .temp_sensor_offset_value(temp_sensor_offset_value), .converter_busy(converter_busy));
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one bus cycle, driven off the falling edge, answer checked after
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic h);
        @(negedge clock);
        sfr_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clock);
        sfr_req = '0;
        if (!w) begin
            chk(sfr_rdata, d);
            chk(sfr_hit, h);
        end
    endtask : acc
    task automatic summarize;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (20) @(negedge clock);
        sys_rst = 1'b0;
        acc(1'b0, 8'hBB, 8'h1F, 1'b1);
        acc(1'b0, 8'hD1, 8'h18, 1'b1);
        // every select code, top bits written as ones
        for (int c = 0; c < 32; c++) begin
            exp_route.port01 = (c < 16) ? 16'h0001 << c : 16'h0000;
            exp_route.port2 = (c >= 16 && c <= 22) ? 7'h01 << (c - 16) : 7'h00;
            exp_route[4:0] = {c == 27, c == 28, c == 29, c == 30, c == 31};
            acc(1'b1, 8'hBB, 8'hE0 | 8'(c), 1'b0);
            chk(analog_input_mux, exp_route);
            acc(1'b0, 8'hBB, 8'(c), 1'b1);
        end
        // offset writes are dropped
        acc(1'b1, 8'h86, 8'h00, 1'b0);
        acc(1'b0, 8'h86, TRIM[9:2], 1'b1);
        acc(1'b1, 8'h85, 8'hFF, 1'b0);
        acc(1'b0, 8'h85, {TRIM[1:0], 6'h00}, 1'b1);
        acc(1'b0, 8'h00, 8'h00, 1'b0);
        // every source, ground select and precision follow the low bit, unused bits written as ones and read as zero
        for (int s = 0; s < 4; s++) begin
            acc(1'b1, 8'hD1, {2'b11, s[0], s[1:0], s[1], 1'b1, s[0]}, 1'b0);
            chk(ref_route[6:3], 4'h8 >> s);
            chk({ref_route.analog_ground, temp_sensor_enable, ref_route.precision_on}, {s[0], s[1], s[0]});
            acc(1'b0, 8'hD1, {2'b00, s[0], s[1:0], s[1], 1'b0, s[0]}, 1'b1);
        end
        // calibration setup: sensor on, routed to the positive input, device ground
        acc(1'b1, 8'hD1, 8'h1C, 1'b0);
        acc(1'b1, 8'hBB, 8'h1B, 1'b0);
        chk({analog_input_mux.sensor, temp_sensor_enable, ref_route.analog_ground}, 3'b110);
        // high-speed reference follows activity
        repeat (8) begin
            @(posedge clock);
            busy_seen = converter_busy;
            @(negedge clock);
            chk(ref_route.high_speed_on, busy_seen);
        end
        // second reset, then a write lost while frozen
        sys_rst = 1'b1;
        @(negedge clock);
        sys_rst = 1'b0;
        acc(1'b0, 8'hD1, 8'h18, 1'b1);
        clk_en = 1'b0;
        acc(1'b1, 8'hBB, 8'h05, 1'b0);
        clk_en = 1'b1;
        acc(1'b0, 8'hBB, 8'h1F, 1'b1);
        summarize;
    end
    // watchdog far beyond the run length
    initial begin
        #1000000;
        miscompares++;
        summarize;
    end
endmodule : tb_top
bind adc_front_ctrl adc_front_checker i_adc_front_checker (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .converter_busy(converter_busy),
    .temp_sensor_offset_value(temp_sensor_offset_value), .analog_input_mux(analog_input_mux),
    .ref_route(ref_route), .temp_sensor_enable(temp_sensor_enable));
